/* fpe_array_model.sv */
// Purpose: flash array stand-in with a self-timed cycle
// Assumes: one launch at a time, same clock as the controller
// Notes: fixed 20-cycle cycle; failNext turns the end into an abort
`timescale 1ns/1ps
`default_nettype none
module fpe_array_model (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic flashStart,
  input  wire logic failNext,
  output logic      flashDone,
  output logic      flashAbort
);
  logic [4:0] busyCount;
  always_ff @(posedge sys_clk) begin
    flashDone  <= 1'b0;
    flashAbort <= 1'b0;
    if (!reset_n) begin
      busyCount <= 5'h00;
    end else if (flashStart) begin
      busyCount <= 5'h14;
    end else if (busyCount == 5'h01) begin
      busyCount  <= 5'h00;
      flashDone  <= !failNext;
      flashAbort <= failNext;
    end else if (busyCount != 5'h00) begin
      busyCount <= busyCount - 5'h01;
    end
  end
endmodule
`default_nettype wire

/* fpe_ctrl_assertions.sv */
// Purpose: port checks for fpe_flash_ctrl
// Assumes: reset_n is the only reset that acts on the checked ports (warmReset_n only clears the key sequencer)
// Notes: bound to every instance of the control block
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"
module fpe_ctrl_assertions (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        flashDone,
  input wire logic        flashAbort,
  input wire logic        flashStart,
  input wire logic [3:0]  flashCmd,
  input wire logic [23:0] flashAddr,
  input wire logic        cpuStall
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_start_stall: assert property (flashStart |-> cpuStall)
    else $error("launch without stall");
  a_stall_cause: assert property ($rose(cpuStall) |-> flashStart)
    else $error("stall without launch");
  a_start_pulse: assert property (flashStart |=> !flashStart)
    else $error("launch pulse too long");
  a_stall_hold: assert property (
    cpuStall && !flashDone && !flashAbort |=> cpuStall)
    else $error("stall dropped early");
  a_stall_release: assert property (
    cpuStall && (flashDone || flashAbort) |=> !cpuStall)
    else $error("stall not released");
  a_cmd_valid: assert property (
    flashStart |-> flashCmd inside {[4'h1:4'h7]})
    else $error("bad command launched");
  a_cmd_stable: assert property (cpuStall && $past(cpuStall)
    |-> $stable(flashCmd) && $stable(flashAddr))
    else $error("target moved in cycle");
  a_page_align: assert property (flashStart && flashCmd == 4'h3
    |-> flashAddr[9:0] == 10'h000)
    else $error("page erase not aligned");
  a_row_align: assert property (flashStart && flashCmd == 4'h6
    |-> flashAddr[6:0] == 7'h00)
    else $error("row program not aligned");
  c_page: cover property (flashStart && flashCmd == 4'h3);
  c_abort: cover property (cpuStall && flashAbort);
  c_decerr: cover property (s_axi_bvalid && s_axi_bresp == `FPE_RESP_DECERR);
endmodule
bind fpe_flash_ctrl fpe_ctrl_assertions chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .flashDone(flashDone),
  .flashAbort(flashAbort), .flashStart(flashStart), .flashCmd(flashCmd),
  .flashAddr(flashAddr), .cpuStall(cpuStall));
`default_nettype wire

/* fpe_defines.svh */
// Purpose: constants for the flash program/erase control block
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes: offsets of the page, pointer and status words are local
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

`define FPE_OFS_CTRL     8'h00
`define FPE_OFS_KEY      8'h04
`define FPE_OFS_PAGE     8'h08
`define FPE_OFS_PTR      8'h0c
`define FPE_OFS_STAT     8'h10

`define FPE_BIT_START    15
`define FPE_BIT_ENABLE   14
`define FPE_BIT_ERROR    13
`define FPE_BIT_ERASE    6
`define FPE_CTRL_MASK    16'he04f

`define FPE_KEY_FIRST    8'h55
`define FPE_KEY_SECOND   8'haa

`define FPE_CODE_BULK    4'hf
`define FPE_CODE_SEG     4'hd
`define FPE_CODE_WORD    4'h3
`define FPE_CODE_PAGE    4'h2
`define FPE_CODE_ROW     4'h1
`define FPE_CODE_CFG     4'h0

`define FPE_PAGE_MASK    24'hfffc00
`define FPE_ROW_MASK     24'hffff80
`define FPE_ROW_WORDS    7'h40

`define FPE_RESP_OKAY    2'b00
`define FPE_RESP_SLVERR  2'b10
`define FPE_RESP_DECERR  2'b11

`endif

/* fpe_flash_ctrl.sv */
// Purpose: run-time self-programming control of on-chip program flash
// Assumes: array runs on sys_clk and pulses flashDone at cycle end
// Notes: reset_n is the power-on reset; warmReset_n spares control bits
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"

// Behaviour
// - start bit launches cycle, clears when done
// - enable bit gates all program and erase
// - error flag marks bad sequence or abort
// - erase bit picks erase or program meaning
// - erase codes bulk, segment, page, config byte
// - program codes word, row, config byte
// - unlisted operation codes are never executed
// - control bits clear only on power-on reset
// - unused control bits read zero, ignore writes
// - key register write-only, reads as zero
// - operations need 0x55 then 0xAA first
// - processor stalls while a cycle runs
// - page erase covers eight-row aligned page
// - row program commits 64 buffered words
// - target address is page byte plus pointer
module fpe_flash_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        warmReset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tableWriteHigh,
  input  wire logic        flashDone,
  input  wire logic        flashAbort,
  output logic             flashStart,
  output logic [3:0]       flashCmd,
  output logic [23:0]      flashAddr,
  output logic             cpuStall
);

  function automatic fpe_pkg::fpe_op_t decodeOp(
    input logic       eraseSel,
    input logic [3:0] code
  );
    fpe_pkg::fpe_op_t op;
    op = fpe_pkg::FPE_OP_INVALID;
    if (eraseSel) begin
      case (code)
        `FPE_CODE_BULK: op = fpe_pkg::FPE_OP_BULK;
        `FPE_CODE_SEG:  op = fpe_pkg::FPE_OP_SEGMENT;
        `FPE_CODE_PAGE: op = fpe_pkg::FPE_OP_PAGE;
        `FPE_CODE_CFG:  op = fpe_pkg::FPE_OP_CFG_ERS;
        `FPE_CODE_WORD: op = fpe_pkg::FPE_OP_NOP;
        `FPE_CODE_ROW:  op = fpe_pkg::FPE_OP_NOP;
        default:        op = fpe_pkg::FPE_OP_INVALID;
      endcase
    end else begin
      case (code)
        `FPE_CODE_WORD: op = fpe_pkg::FPE_OP_WORD;
        `FPE_CODE_ROW:  op = fpe_pkg::FPE_OP_ROW;
        `FPE_CODE_CFG:  op = fpe_pkg::FPE_OP_CFG_PRG;
        `FPE_CODE_BULK: op = fpe_pkg::FPE_OP_NOP;
        `FPE_CODE_SEG:  op = fpe_pkg::FPE_OP_NOP;
        `FPE_CODE_PAGE: op = fpe_pkg::FPE_OP_NOP;
        default:        op = fpe_pkg::FPE_OP_INVALID;
      endcase
    end
    return op;
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    return (addr == `FPE_OFS_CTRL) || (addr == `FPE_OFS_KEY) ||
           (addr == `FPE_OFS_PAGE) || (addr == `FPE_OFS_PTR) ||
           (addr == `FPE_OFS_STAT);
  endfunction

  // register fields, key and cycle sequencer state
  logic              startBit;
  logic              enableBit;
  logic              errorFlag;
  logic              eraseSel;
  logic [3:0]        opField;
  logic [7:0]        tablePage;
  logic [15:0]       pointer;
  logic [6:0]        bufCount;
  fpe_pkg::fpe_key_t keyState;
  fpe_pkg::fpe_state_t state;
  fpe_pkg::fpe_op_t  launchOp;

  // write channel holding and decoded write and cycle strobes
  logic              awHeld;
  logic              wHeld;
  logic [7:0]        wrAddr;
  logic [31:0]       wrData;
  logic [3:0]        wrStrb;
  logic              wrFire;
  logic              ctrlWrite;
  logic              keyWrite;
  logic              startReq;
  logic              goodStart;
  logic              nopStart;
  logic              badStart;
  logic              cycleEnd;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign wrFire        = awHeld && wHeld && !s_axi_bvalid;
  assign ctrlWrite     = wrFire && (wrAddr == `FPE_OFS_CTRL) &&
                         wrStrb[1];
  assign keyWrite      = wrFire && (wrAddr == `FPE_OFS_KEY) && wrStrb[0];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      wrAddr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      wrAddr <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wHeld  <= 1'b0;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld  <= 1'b1;
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FPE_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      if (!isMapped(wrAddr)) begin
        s_axi_bresp <= `FPE_RESP_DECERR;
      end else begin
        s_axi_bresp <= `FPE_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // a start attempt is any write of a one to the start bit while idle
  assign startReq  = ctrlWrite && wrData[`FPE_BIT_START] &&
                     (state == fpe_pkg::FPE_IDLE);
  assign launchOp  = decodeOp(wrData[`FPE_BIT_ERASE], wrData[3:0]);
  assign goodStart = startReq && wrData[`FPE_BIT_ENABLE] &&
                     (keyState == fpe_pkg::FPE_KEY_ARMED) &&
                     (launchOp != fpe_pkg::FPE_OP_INVALID);
  assign nopStart  = goodStart && (launchOp == fpe_pkg::FPE_OP_NOP);
  assign badStart  = startReq && !goodStart;
  assign cycleEnd  = (state == fpe_pkg::FPE_RUN) &&
                     (flashDone || flashAbort);

  // key sequencer: any write other than the expected key byte disarms; a first key byte always restarts the pair
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !warmReset_n) begin
      keyState <= fpe_pkg::FPE_KEY_NONE;
    end else if (wrFire) begin
      case (keyState)
        fpe_pkg::FPE_KEY_NONE: begin
          if (keyWrite && wrData[7:0] == `FPE_KEY_FIRST) begin
            keyState <= fpe_pkg::FPE_KEY_HALF;
          end
        end
        fpe_pkg::FPE_KEY_HALF: begin
          if (keyWrite && wrData[7:0] == `FPE_KEY_SECOND) begin
            keyState <= fpe_pkg::FPE_KEY_ARMED;
          end else if (keyWrite && wrData[7:0] == `FPE_KEY_FIRST) begin
            keyState <= fpe_pkg::FPE_KEY_HALF;
          end else begin
            keyState <= fpe_pkg::FPE_KEY_NONE;
          end
        end
        fpe_pkg::FPE_KEY_ARMED: begin
          // one unlock is spent by the next register write of any kind
          if (keyWrite && wrData[7:0] == `FPE_KEY_FIRST) begin
            keyState <= fpe_pkg::FPE_KEY_HALF;
          end else begin
            keyState <= fpe_pkg::FPE_KEY_NONE;
          end
        end
        default: keyState <= fpe_pkg::FPE_KEY_NONE;
      endcase
    end
  end

  // cycle sequencer
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= fpe_pkg::FPE_IDLE;
    end else begin
      case (state)
        fpe_pkg::FPE_IDLE: begin
          if (goodStart && !nopStart) begin
            state <= fpe_pkg::FPE_RUN;
          end
        end
        fpe_pkg::FPE_RUN: begin
          if (cycleEnd) begin
            state <= fpe_pkg::FPE_IDLE;
          end
        end
        default: state <= fpe_pkg::FPE_IDLE;
      endcase
    end
  end

  // start bit: set only by a launch, cleared by the end of the cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      startBit <= 1'b0;
    end else if (goodStart && !nopStart) begin
      startBit <= 1'b1;
    end else if (cycleEnd) begin
      startBit <= 1'b0;
    end
  end

  // plain fields; writes while a cycle runs are dropped
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      enableBit <= 1'b0;
      eraseSel  <= 1'b0;
      opField   <= 4'h0;
    end else if (ctrlWrite && state == fpe_pkg::FPE_IDLE) begin
      enableBit <= wrData[`FPE_BIT_ENABLE];
      eraseSel  <= wrData[`FPE_BIT_ERASE];
      opField   <= wrData[3:0];
    end
  end

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      errorFlag <= 1'b0;
    end else if (badStart || (cycleEnd && flashAbort)) begin
      errorFlag <= 1'b1;
    end else if (goodStart || (cycleEnd && flashDone)) begin
      errorFlag <= 1'b0;
    end else if (ctrlWrite && state == fpe_pkg::FPE_IDLE) begin
      errorFlag <= wrData[`FPE_BIT_ERROR];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tablePage <= 8'h00;
      pointer   <= 16'h0000;
    end else if (wrFire && state == fpe_pkg::FPE_IDLE) begin
      if (wrAddr == `FPE_OFS_PAGE && wrStrb[0]) begin
        tablePage <= wrData[7:0];
      end
      if (wrAddr == `FPE_OFS_PTR) begin
        if (wrStrb[0]) begin
          pointer[7:0] <= wrData[7:0];
        end
        if (wrStrb[1]) begin
          pointer[15:8] <= wrData[15:8];
        end
      end
    end
  end

  // holding buffer fill count; saturates at one full row
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bufCount <= 7'h00;
    end else if (cycleEnd && flashCmd == fpe_pkg::FPE_OP_ROW) begin
      bufCount <= 7'h00;
    end else if (tableWriteHigh && bufCount != `FPE_ROW_WORDS) begin
      bufCount <= bufCount + 7'h01;
    end
  end

  // array command port
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flashStart <= 1'b0;
      flashCmd   <= fpe_pkg::FPE_OP_NOP;
      flashAddr  <= 24'h000000;
    end else begin
      flashStart <= goodStart && !nopStart;
      if (goodStart && !nopStart) begin
        flashCmd <= launchOp;
        case (launchOp)
          fpe_pkg::FPE_OP_PAGE:
            flashAddr <= {tablePage, pointer} & `FPE_PAGE_MASK;
          fpe_pkg::FPE_OP_ROW:
            flashAddr <= {tablePage, pointer} & `FPE_ROW_MASK;
          default:
            flashAddr <= {tablePage, pointer};
        endcase
      end
    end
  end

  // stall is held from launch to the end of the cycle
  assign cpuStall = (state == fpe_pkg::FPE_RUN);

  // read channel: one answer, one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FPE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `FPE_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      case (s_axi_araddr)
        `FPE_OFS_CTRL:
          s_axi_rdata <= {16'h0000, startBit, enableBit, errorFlag,
                          6'h00, eraseSel, 2'b00, opField};
        `FPE_OFS_KEY:
          s_axi_rdata <= 32'h00000000;
        `FPE_OFS_PAGE:
          s_axi_rdata <= {24'h000000, tablePage};
        `FPE_OFS_PTR:
          s_axi_rdata <= {16'h0000, pointer};
        `FPE_OFS_STAT:
          s_axi_rdata <= {22'h000000, cpuStall,
                          keyState == fpe_pkg::FPE_KEY_ARMED,
                          1'b0, bufCount};
        default:
          s_axi_rresp <= `FPE_RESP_DECERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* fpe_pkg.sv */
// Purpose: types for the flash program/erase control block
// Assumes: constants live in fpe_defines.svh
// Notes: command codes are what the array sees on flashCmd
package fpe_pkg;

  typedef enum logic [0:0] {
    FPE_IDLE = 1'b0,
    FPE_RUN  = 1'b1
  } fpe_state_t;

  typedef enum logic [1:0] {
    FPE_KEY_NONE  = 2'b00,
    FPE_KEY_HALF  = 2'b01,
    FPE_KEY_ARMED = 2'b10
  } fpe_key_t;

  typedef enum logic [3:0] {
    FPE_OP_NOP      = 4'h0,
    FPE_OP_BULK     = 4'h1,
    FPE_OP_SEGMENT  = 4'h2,
    FPE_OP_PAGE     = 4'h3,
    FPE_OP_CFG_ERS  = 4'h4,
    FPE_OP_WORD     = 4'h5,
    FPE_OP_ROW      = 4'h6,
    FPE_OP_CFG_PRG  = 4'h7,
    FPE_OP_INVALID  = 4'hf
  } fpe_op_t;

endpackage

/* testbench.sv */
// Purpose: register-level test of fpe_flash_ctrl with an array model
// Assumes: bready, rready and wstrb stay high for the whole run
// Notes: launches are counted from flashStart, not from status bits
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"
module testbench;
  logic        sys_clk, reset_n, warmReset_n, tableWriteHigh, failNext;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, ctl;
  logic [3:0]  flashCmd, lastCmd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        flashDone, flashAbort, flashStart, cpuStall;
  logic [23:0] flashAddr, lastAddr;
  logic [4:0]  ex;
  int          errors, n_compared, nStarts, cycles, n;
  fpe_flash_ctrl dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .warmReset_n(warmReset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .tableWriteHigh(tableWriteHigh),
    .flashDone(flashDone), .flashAbort(flashAbort),
    .flashStart(flashStart), .flashCmd(flashCmd),
    .flashAddr(flashAddr), .cpuStall(cpuStall));
  fpe_array_model array_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .flashStart(flashStart),
    .failNext(failNext), .flashDone(flashDone), .flashAbort(flashAbort));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (flashStart === 1'b1) begin
      nStarts  <= nStarts + 1;
      lastCmd  <= flashCmd;
      lastAddr <= flashAddr;
    end
    if (cycles == 30000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic unlock();
    wr(`FPE_OFS_KEY, 32'h55);
    wr(`FPE_OFS_KEY, 32'haa);
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge sys_clk);
    while (cpuStall !== 1'b0) @(posedge sys_clk);
  endtask
  function automatic logic [4:0] exp_op(input logic er, input logic [3:0] c);
    case ({er, c})
      5'h1f: return 5'h01;
      5'h1d: return 5'h02;
      5'h12: return 5'h03;
      5'h10: return 5'h04;
      5'h03: return 5'h05;
      5'h01: return 5'h06;
      5'h00: return 5'h07;
      5'h13, 5'h11, 5'h0f, 5'h0d, 5'h02: return 5'h00;
      default: return 5'h10;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    warmReset_n = 1'b1;
    tableWriteHigh = 1'b0;
    failNext = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    {errors, n_compared, nStarts, cycles} = '0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h0);
    wr(`FPE_OFS_CTRL, 32'hffff7fff);
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h604f);
    wr(8'h40, 32'h1);
    chk(32'(resp), 32'(`FPE_RESP_DECERR));
    rdr(8'h40);
    chk({rd[31:2], resp}, 32'(`FPE_RESP_DECERR));
    // page erase, then two reads and an ignored write while stalled
    wr(`FPE_OFS_PAGE, 32'h12);
    wr(`FPE_OFS_PTR, 32'h3456);
    chk(32'(resp), 32'(`FPE_RESP_OKAY));
    unlock();
    rdr(`FPE_OFS_KEY);
    chk(rd, 32'h0);
    chk(32'(resp), 32'(`FPE_RESP_OKAY));
    rdr(`FPE_OFS_STAT);
    chk(32'(rd[8]), 32'h1);
    wr(`FPE_OFS_CTRL, 32'hc042);
    repeat (2) @(posedge sys_clk);
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'hc042);
    rdr(`FPE_OFS_STAT);
    chk(32'(rd[9:8]), 32'h2);
    wr(`FPE_OFS_CTRL, 32'h0);
    wait_idle();
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h4042);
    chk(32'(lastCmd), 32'h3);
    chk(32'(lastAddr), 32'h123400);
    // every code under both interpretations
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 16; c++) begin
        ctl = {16'h0, 2'b01, 7'h0, e[0], 2'h0, c[3:0]};
        ex = exp_op(e[0], c[3:0]);
        n = nStarts;
        wr(`FPE_OFS_CTRL, ctl);
        unlock();
        wr(`FPE_OFS_CTRL, ctl | 32'h8000);
        wait_idle();
        rdr(`FPE_OFS_CTRL);
        chk(rd, ctl | {18'h0, ex[4], 13'h0});
        chk(32'(nStarts - n), 32'(ex[3:0] != 4'h0));
        if (ex[3:0] != 4'h0) chk(32'(lastCmd), 32'(ex[3:0]));
        if (ex[3:0] == 4'h5) chk(32'(lastAddr), 32'h123456);
      end
    end
    // refused starts: no enable, broken key pair, warm reset
    n = nStarts;
    wr(`FPE_OFS_CTRL, 32'h0042);
    unlock();
    wr(`FPE_OFS_CTRL, 32'h8042);
    wait_idle();
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h2042);
    wr(`FPE_OFS_CTRL, 32'h4042);
    wr(`FPE_OFS_KEY, 32'h55);
    wr(`FPE_OFS_PAGE, 32'h12);
    wr(`FPE_OFS_KEY, 32'haa);
    wr(`FPE_OFS_CTRL, 32'hc042);
    wait_idle();
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h6042);
    wr(`FPE_OFS_CTRL, 32'h4042);
    unlock();
    warmReset_n <= 1'b0;
    @(posedge sys_clk);
    warmReset_n <= 1'b1;
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h4042);
    wr(`FPE_OFS_CTRL, 32'hc042);
    wait_idle();
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h6042);
    chk(32'(nStarts - n), 32'h0);
    // abnormal end of a cycle
    failNext <= 1'b1;
    wr(`FPE_OFS_CTRL, 32'h4042);
    unlock();
    wr(`FPE_OFS_CTRL, 32'hc042);
    wait_idle();
    failNext <= 1'b0;
    rdr(`FPE_OFS_CTRL);
    chk(rd, 32'h6042);
    // row program after loading one full row into the buffers
    wr(`FPE_OFS_CTRL, 32'h4001);
    tableWriteHigh <= 1'b1;
    repeat (64) @(posedge sys_clk);
    tableWriteHigh <= 1'b0;
    rdr(`FPE_OFS_STAT);
    chk(32'(rd[6:0]), 32'h40);
    wr(`FPE_OFS_PAGE, 32'h0);
    wr(`FPE_OFS_PTR, 32'h6012);
    unlock();
    wr(`FPE_OFS_CTRL, 32'hc001);
    wait_idle();
    chk(32'(lastCmd), 32'h6);
    chk(32'(lastAddr), 32'h006000);
    rdr(`FPE_OFS_STAT);
    chk(32'(rd[6:0]), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
